// *** common/pll_clock_params.svh ***
// Purpose: constants for core clock generation and reset release
// Assumes: included by bare name from the package and design files
// Notes:   definitions only
`ifndef PLL_CLOCK_PARAMS_SVH
`define PLL_CLOCK_PARAMS_SVH

// ----------------------------------------------------------------
// widths
// ----------------------------------------------------------------
`define PLL_MULT_W          7
`define PLL_SDR_W           3
`define PLL_DIVSEL_W        2

// ----------------------------------------------------------------
// multiplier loaded from the ratio select pins during reset
// ----------------------------------------------------------------
`define PLL_RATIO_00_MULT   7'h08
`define PLL_RATIO_01_MULT   7'h10
`define PLL_RATIO_10_MULT   7'h20
`define PLL_RATIO_11_MULT   7'h08

// ----------------------------------------------------------------
// reset values
// ----------------------------------------------------------------
`define PLL_DIVSEL_RESET    2'h0
`define PLL_SDR_RESET       3'h2
`define PLL_MULT_RESET      7'h08

// ----------------------------------------------------------------
// fixed ratios and timing counts
// ----------------------------------------------------------------
`define PLL_OSC_FACTOR      2
`define PLL_IN_DIV          2
`define PLL_PERIPH_DIV      2
`define PLL_CORE_RST_REF    4096
`define PLL_CORE_RST_CORE   2

`endif

// *** common/pll_clock_pkg.sv ***
// Purpose: shared types for core clock generation and reset release
// Assumes: constants come from pll_clock_params.svh
// Notes:   types only
`include "pll_clock_params.svh"

package pll_clock_pkg;

  // ----------------------------------------------------------------
  // types
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    DIV_BY_2,
    DIV_BY_4,
    DIV_BY_8,
    DIV_BY_16
  } post_div_sel_t;

  typedef enum {
    ST_HOLD,
    ST_COUNT_REF,
    ST_COUNT_CORE,
    ST_RUN
  } rst_state_t;

  typedef logic [`PLL_MULT_W-1:0] pll_mult_t;
  typedef logic [`PLL_SDR_W-1:0]  sdram_ratio_t;

endpackage

// *** common/clock_div_if.sv ***
// Purpose: carries divider settings and clock enables between modules
// Assumes: one clock domain
// Notes:   ctrl side sets ratios, gen side makes enables
`timescale 1ns/10ps
`default_nettype none

interface clock_div_if;
  pll_clock_pkg::post_div_sel_t div_sel;
  pll_clock_pkg::sdram_ratio_t  sdram_ratio;
  logic                         div_restart;
  logic                         core_en;
  logic                         periph_en;
  logic                         sdram_en;

  modport ctrl (
    output div_sel,
    output sdram_ratio,
    output div_restart,
    input  core_en,
    input  periph_en,
    input  sdram_en
  );

  modport gen (
    input  div_sel,
    input  sdram_ratio,
    input  div_restart,
    output core_en,
    output periph_en,
    output sdram_en
  );
endinterface

`default_nettype wire

// *** design/post_divider.sv ***
// Purpose: oscillator to core, peripheral and sdram clock enables
// Assumes: each clk_sys cycle stands for one oscillator period
// Notes:   enables are one-cycle pulses
`timescale 1ns/10ps
`default_nettype none
`include "pll_clock_params.svh"

module post_divider (
  // clock and reset
  input  wire logic  clk_sys,
  input  wire logic  reset_n,
  // divider link
  clock_div_if.gen   div
);

  // ----------------------------------------------------------------
  // decode
  // ----------------------------------------------------------------
  function automatic logic [4:0] div_value(input pll_clock_pkg::post_div_sel_t sel);
    unique case (sel)
      pll_clock_pkg::DIV_BY_2:  div_value = 5'h02;
      pll_clock_pkg::DIV_BY_4:  div_value = 5'h04;
      pll_clock_pkg::DIV_BY_8:  div_value = 5'h08;
      pll_clock_pkg::DIV_BY_16: div_value = 5'h10;
    endcase
  endfunction

  logic [4:0]                   core_cnt_reg;
  logic                         periph_cnt_reg;
  logic [`PLL_SDR_W-1:0]        sdr_cnt_reg;
  logic                         core_en_reg;
  logic                         periph_en_reg;
  logic                         sdram_en_reg;
  wire  logic [4:0]             core_last;
  wire  logic                   core_hit;
  wire  logic [`PLL_SDR_W-1:0]  sdr_last;
  wire  logic                   sdr_hit;

  assign core_last = div_value(div.div_sel) - 5'h01;
  assign core_hit  = (core_cnt_reg >= core_last);
  // ratio 0 behaves as 1 rather than stalling the sdram clock
  assign sdr_last  = (div.sdram_ratio == '0) ? '0 : div.sdram_ratio - 1'b1;
  assign sdr_hit   = (sdr_cnt_reg >= sdr_last);

  // ----------------------------------------------------------------
  // counters
  // ----------------------------------------------------------------
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      core_cnt_reg   <= 5'h00;
      periph_cnt_reg <= 1'b0;
      sdr_cnt_reg    <= '0;
      core_en_reg    <= 1'b0;
      periph_en_reg  <= 1'b0;
      sdram_en_reg   <= 1'b0;
    end else if (div.div_restart) begin
      core_cnt_reg   <= 5'h00;
      periph_cnt_reg <= 1'b0;
      sdr_cnt_reg    <= '0;
      core_en_reg    <= 1'b0;
      periph_en_reg  <= 1'b0;
      sdram_en_reg   <= 1'b0;
    end else begin
      core_cnt_reg  <= core_hit ? 5'h00 : core_cnt_reg + 5'h01;
      core_en_reg   <= core_hit;
      periph_en_reg <= core_hit && periph_cnt_reg;
      sdram_en_reg  <= core_hit && sdr_hit;
      if (core_hit) begin
        periph_cnt_reg <= ~periph_cnt_reg;
        sdr_cnt_reg    <= sdr_hit ? '0 : sdr_cnt_reg + 1'b1;
      end
    end
  end

  assign div.core_en   = core_en_reg;
  assign div.periph_en = periph_en_reg;
  assign div.sdram_en  = sdram_en_reg;

endmodule

`default_nettype wire

// *** design/pll_clock_and_reset_release.sv ***
// Purpose: core clock ratio control and core reset release
// Assumes: reference clock and board reset pins are synchronous to clk_sys
// Notes:   clk_sys stands for the oscillator; ratios drive enable pulses
//
// What this block does
// - During board reset the multiplier is loaded from the ratio select pins, and software may overwrite it later.
// - The oscillator rate is two times the multiplier times the pll input rate.
// - The core clock is the oscillator divided by a post divider of 2, 4, 8 or 16 chosen by software.
// - During board reset the post divider is forced to 2.
// - The pll input is the reference clock, or the reference clock divided by 2 when input divide is enabled.
// - The peripheral clock runs at half the core clock rate.
// - The sdram clock period is the core clock period times the sdram clock ratio, with a ratio of 0 treated as 1.
// - Core reset stays asserted for 4096 reference cycles plus two core cycles after board reset release.
// - A late board reset release may add one reference cycle, up to 4097.
`timescale 1ns/10ps
`default_nettype none
`include "pll_clock_params.svh"

module pll_clock_and_reset_release #(
  parameter int REF_CYCLES  = `PLL_CORE_RST_REF,
  parameter int CORE_CYCLES = `PLL_CORE_RST_CORE
) (
  // clock and reset
  input  wire logic                    clk_sys,
  input  wire logic                    reset_n,
  // board pins
  input  wire logic                    reference_clock_in,
  input  wire logic                    board_reset_n,
  input  wire logic [1:0]              ratio_select_pins,
  // power management control write
  input  wire logic                    power_mgmt_control_wr,
  input  wire logic [`PLL_MULT_W-1:0]  wr_pll_multiplier,
  input  wire logic [1:0]              wr_post_div_sel,
  input  wire logic                    wr_input_divide_enable,
  input  wire logic [`PLL_SDR_W-1:0]   wr_sdram_clock_ratio,
  // power management control status
  output logic [`PLL_MULT_W-1:0]       pll_multiplier,
  output logic [4:0]                   pll_post_divider,
  output logic                         input_divide_enable,
  output logic [`PLL_SDR_W-1:0]        sdram_clock_ratio,
  output logic [`PLL_MULT_W:0]         osc_to_input_ratio,
  // clock enables and reset
  output logic                         pll_input_en,
  output logic                         core_clk_en,
  output logic                         periph_clk_en,
  output logic                         sdram_clock_en,
  output logic                         core_reset_n
);

  // ----------------------------------------------------------------
  // decode functions
  // ----------------------------------------------------------------
  function automatic pll_clock_pkg::pll_mult_t ratio_mult(input logic [1:0] pins);
    unique case (pins)
      2'h0: ratio_mult = `PLL_RATIO_00_MULT;
      2'h1: ratio_mult = `PLL_RATIO_01_MULT;
      2'h2: ratio_mult = `PLL_RATIO_10_MULT;
      2'h3: ratio_mult = `PLL_RATIO_11_MULT;
    endcase
  endfunction

  function automatic logic [4:0] div_value(input logic [1:0] sel);
    div_value = 5'h02 << sel;
  endfunction

  // ----------------------------------------------------------------
  // pin sampling
  // ----------------------------------------------------------------
  logic       ref_q_reg;
  logic       brst_q_reg;
  logic       in_half_reg;
  logic       pll_in_en_reg;
  wire  logic ref_rise;
  wire  logic in_reset;

  assign ref_rise = reference_clock_in && !ref_q_reg;
  assign in_reset = !brst_q_reg;

  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      ref_q_reg  <= 1'b0;
      brst_q_reg <= 1'b0;
    end else begin
      ref_q_reg  <= reference_clock_in;
      brst_q_reg <= board_reset_n;
    end
  end

  // ----------------------------------------------------------------
  // power management control
  // ----------------------------------------------------------------
  pll_clock_pkg::pll_mult_t      mult_reg;
  pll_clock_pkg::post_div_sel_t  div_sel_reg;
  logic                          input_divide_enable_reg;
  pll_clock_pkg::sdram_ratio_t   sdr_reg;

  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      mult_reg    <= `PLL_MULT_RESET;
      div_sel_reg <= pll_clock_pkg::post_div_sel_t'(`PLL_DIVSEL_RESET);
      input_divide_enable_reg   <= 1'b0;
      sdr_reg     <= `PLL_SDR_RESET;
    end else if (in_reset) begin
      mult_reg    <= ratio_mult(ratio_select_pins);
      div_sel_reg <= pll_clock_pkg::DIV_BY_2;
      input_divide_enable_reg   <= 1'b0;
      sdr_reg     <= `PLL_SDR_RESET;
    end else if (power_mgmt_control_wr) begin
      // range check of the product is left to software
      mult_reg    <= wr_pll_multiplier;
      div_sel_reg <= pll_clock_pkg::post_div_sel_t'(wr_post_div_sel);
      input_divide_enable_reg   <= wr_input_divide_enable;
      sdr_reg     <= wr_sdram_clock_ratio;
    end
  end

  // ----------------------------------------------------------------
  // pll input divider
  // ----------------------------------------------------------------
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      in_half_reg   <= 1'b0;
      pll_in_en_reg <= 1'b0;
    end else begin
      if (ref_rise) begin
        in_half_reg <= ~in_half_reg;
      end
      pll_in_en_reg <= ref_rise && (!input_divide_enable_reg || in_half_reg);
    end
  end

  // ----------------------------------------------------------------
  // post divider and derived clocks
  // ----------------------------------------------------------------
  clock_div_if div_link ();

  assign div_link.div_sel     = div_sel_reg;
  assign div_link.sdram_ratio = sdr_reg;
  // restart on every setting change keeps enables glitch free
  assign div_link.div_restart = in_reset || power_mgmt_control_wr;

  post_divider u_post_divider (
    .clk_sys (clk_sys),
    .reset_n (reset_n),
    .div     (div_link.gen)
  );

  // ----------------------------------------------------------------
  // core reset release
  // ----------------------------------------------------------------
  pll_clock_pkg::rst_state_t  state_reg;
  pll_clock_pkg::rst_state_t  state_next;
  logic [12:0]                cnt_reg;
  logic [12:0]                cnt_next;
  logic                       core_rst_n_reg;
  wire  logic [12:0]          ref_last;
  wire  logic [12:0]          core_last;

  assign ref_last  = 13'(REF_CYCLES - 1);
  assign core_last = 13'(CORE_CYCLES - 1);

  always_comb begin
    state_next = state_reg;
    cnt_next   = cnt_reg;
    unique case (state_reg)
      pll_clock_pkg::ST_HOLD: begin
        cnt_next = 13'h0000;
        if (!in_reset) begin
          state_next = pll_clock_pkg::ST_COUNT_REF;
        end
      end
      pll_clock_pkg::ST_COUNT_REF: begin
        if (ref_rise) begin
          cnt_next = cnt_reg + 13'h0001;
          if (cnt_reg == ref_last) begin
            cnt_next   = 13'h0000;
            state_next = pll_clock_pkg::ST_COUNT_CORE;
          end
        end
      end
      pll_clock_pkg::ST_COUNT_CORE: begin
        if (div_link.core_en) begin
          cnt_next = cnt_reg + 13'h0001;
          if (cnt_reg == core_last) begin
            state_next = pll_clock_pkg::ST_RUN;
          end
        end
      end
      pll_clock_pkg::ST_RUN: begin
        cnt_next = 13'h0000;
      end
    endcase
    if (in_reset) begin
      state_next = pll_clock_pkg::ST_HOLD;
      cnt_next   = 13'h0000;
    end
  end

  // a release landing between samples costs one more reference edge
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      state_reg      <= pll_clock_pkg::ST_HOLD;
      cnt_reg        <= 13'h0000;
      core_rst_n_reg <= 1'b0;
    end else begin
      state_reg      <= state_next;
      cnt_reg        <= cnt_next;
      core_rst_n_reg <= (state_next == pll_clock_pkg::ST_RUN);
    end
  end

  // ----------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------
  assign pll_multiplier      = mult_reg;
  assign pll_post_divider    = div_value(div_sel_reg);
  assign input_divide_enable = input_divide_enable_reg;
  assign sdram_clock_ratio   = sdr_reg;
  assign osc_to_input_ratio  = (`PLL_MULT_W+1)'(`PLL_OSC_FACTOR * mult_reg);
  assign pll_input_en        = pll_in_en_reg;
  assign core_clk_en         = div_link.core_en;
  assign periph_clk_en       = div_link.periph_en;
  assign sdram_clock_en      = div_link.sdram_en;
  assign core_reset_n        = core_rst_n_reg;

endmodule

`default_nettype wire

// *** verification/pll_clock_checker.sv ***
// Purpose: port checker for clock ratios and core reset release
// Assumes: bound to the top module, one clock domain
// Notes:   pulse spacing judged only after a long undisturbed stretch
`timescale 1ns/10ps
`default_nettype none
`include "pll_clock_params.svh"

module pll_clock_checker #(
  parameter int REF_CYCLES  = `PLL_CORE_RST_REF,
  parameter int CORE_CYCLES = `PLL_CORE_RST_CORE
) (
  // clock, reset and board pins
  input wire logic                   clk_sys,
  input wire logic                   reset_n,
  input wire logic                   reference_clock_in,
  input wire logic                   board_reset_n,
  input wire logic [1:0]             ratio_select_pins,
  input wire logic                   power_mgmt_control_wr,
  // status and enables
  input wire logic [`PLL_MULT_W-1:0] pll_multiplier,
  input wire logic [4:0]             pll_post_divider,
  input wire logic                   input_divide_enable,
  input wire logic [`PLL_SDR_W-1:0]  sdram_clock_ratio,
  input wire logic [`PLL_MULT_W:0]   osc_to_input_ratio,
  input wire logic                   pll_input_en,
  input wire logic                   core_clk_en,
  input wire logic                   periph_clk_en,
  input wire logic                   sdram_clock_en,
  input wire logic                   core_reset_n
);
  localparam logic [`PLL_MULT_W-1:0] MT [4] = '{`PLL_RATIO_00_MULT, `PLL_RATIO_01_MULT,
                                               `PLL_RATIO_10_MULT, `PLL_RATIO_11_MULT};
  logic [7:0] qt_reg;
  logic [4:0] gap_reg;
  logic [1:0] pc_reg;
  logic [2:0] sc_reg;
  logic [1:0] ic_reg;
  logic       rq_reg;
  int         rr_reg;
  wire logic  ref_rise = reference_clock_in && !rq_reg;
  wire logic  quiet    = &qt_reg;
  wire logic  disturb  = power_mgmt_control_wr || !board_reset_n;

  // ------
  // helper counters
  // ------
  // writes and board reset restart the dividers, so spacing is not judged then
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      qt_reg <= 8'h00;
      rq_reg <= 1'b0;
      rr_reg <= 0;
    end else begin
      qt_reg <= disturb ? 8'h00 : qt_reg + {7'h00, !quiet};
      rq_reg <= reference_clock_in;
      rr_reg <= !board_reset_n ? 0 : rr_reg + int'(ref_rise && rr_reg < REF_CYCLES + 4);
    end
  end

  always_ff @(posedge clk_sys) begin
    gap_reg <= core_clk_en ? 5'h00 : gap_reg + 5'h01;
    pc_reg  <= periph_clk_en ? 2'h0 : pc_reg + {1'b0, core_clk_en};
    sc_reg  <= sdram_clock_en ? 3'h0 : sc_reg + {2'h0, core_clk_en};
    ic_reg  <= pll_input_en ? {1'b0, ref_rise} : ic_reg + {1'b0, ref_rise};
  end

  // ------
  // assertions
  // ------
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!reset_n);

  a_core_spacing: assert property (
    core_clk_en && quiet |-> gap_reg == pll_post_divider - 5'h01)
    else $error("core enable spacing wrong");
  a_periph_half: assert property (
    periph_clk_en && quiet |-> core_clk_en && pc_reg == 2'h1)
    else $error("peripheral enable not every second core pulse");
  a_sdram_ratio: assert property (
    sdram_clock_en && quiet |->
      sc_reg == ((sdram_clock_ratio == 3'h0) ? 3'h0 : sdram_clock_ratio - 3'h1))
    else $error("sdram enable spacing wrong");
  a_input_divide: assert property (
    pll_input_en && quiet |-> ic_reg == (input_divide_enable ? 2'h2 : 2'h1))
    else $error("pll input enable spacing wrong");
  a_osc_double: assert property (
    osc_to_input_ratio == {pll_multiplier, 1'b0})
    else $error("oscillator ratio not twice multiplier");
  a_reset_load: assert property (
    !board_reset_n [*3] |-> pll_multiplier == MT[ratio_select_pins]
      && pll_post_divider == 5'h02 && !core_reset_n)
    else $error("board reset values wrong");
  a_release_early: assert property (
    board_reset_n && $past(board_reset_n) && $past(board_reset_n, 2)
      && rr_reg < REF_CYCLES |-> !core_reset_n)
    else $error("core reset released too early");
  a_release_late: assert property (
    rr_reg == REF_CYCLES + 4 |-> core_reset_n)
    else $error("core reset released too late");
  a_release_core: assert property (
    $rose(core_reset_n) |-> $past(core_clk_en) || $past(core_clk_en, 2))
    else $error("core reset release not after core pulse");

  c_release: cover property ($rose(core_reset_n));
  c_sdram_max: cover property (sdram_clock_en && sdram_clock_ratio == 3'h7 && quiet);
  c_input_divide_enable: cover property (pll_input_en && input_divide_enable && quiet);
endmodule

bind pll_clock_and_reset_release pll_clock_checker #(
  .REF_CYCLES(REF_CYCLES), .CORE_CYCLES(CORE_CYCLES)
) pll_clock_checker_inst (
  .clk_sys(clk_sys), .reset_n(reset_n), .reference_clock_in(reference_clock_in),
  .board_reset_n(board_reset_n), .ratio_select_pins(ratio_select_pins),
  .power_mgmt_control_wr(power_mgmt_control_wr), .pll_multiplier(pll_multiplier),
  .pll_post_divider(pll_post_divider), .input_divide_enable(input_divide_enable),
  .sdram_clock_ratio(sdram_clock_ratio), .osc_to_input_ratio(osc_to_input_ratio),
  .pll_input_en(pll_input_en), .core_clk_en(core_clk_en), .periph_clk_en(periph_clk_en),
  .sdram_clock_en(sdram_clock_en), .core_reset_n(core_reset_n)
);

`default_nettype wire

// *** verification/ref_board_model.sv ***
// Purpose: reference oscillator and board reset source
// Assumes: clk_sys falling edge paces the board
// Notes:   ratio pins change only when reset is asserted
`timescale 1ns/10ps
`default_nettype none

module ref_board_model #(
  parameter int HALF    = 2,
  parameter int MIN_LOW = 24
) (
  // clock and requests
  input  wire logic       clk_sys,
  input  wire logic       hold_req,
  input  wire logic [1:0] ratio_req,
  // board pins
  output logic            reference_clock_in,
  output logic            board_reset_n,
  output logic [1:0]      ratio_select_pins
);
  int hc = 0;
  int lc = 0;

  initial begin
    reference_clock_in = 1'b0;
    board_reset_n = 1'b0;
    ratio_select_pins = 2'h0;
  end

  // runs free from time zero, long before any release
  always @(negedge clk_sys) begin
    hc = (hc + 1) % HALF;
    if (hc == 0) reference_clock_in <= !reference_clock_in;
  end

  // low time covers six reference periods and ratio pin setup
  always @(negedge clk_sys) begin
    if (hold_req && board_reset_n) begin
      ratio_select_pins <= ratio_req;
      lc <= 0;
    end else if (!board_reset_n && lc < MIN_LOW) lc <= lc + 1;
    board_reset_n <= !hold_req && (board_reset_n || lc >= MIN_LOW);
  end
endmodule

`default_nettype wire

// *** verification/pll_clock_and_reset_release_tb.sv ***
// Purpose: self-checking bench for clock ratios and core reset release
// Assumes: shortened release count, reference period of four cycles
// Notes:   inputs change at the falling edge
`timescale 1ns/10ps
`default_nettype none
`include "pll_clock_params.svh"

module pll_clock_and_reset_release_tb;
  localparam int REF = 8;
  localparam logic [6:0] MT [4] = '{`PLL_RATIO_00_MULT, `PLL_RATIO_01_MULT,
                                   `PLL_RATIO_10_MULT, `PLL_RATIO_11_MULT};
  logic       clk_sys = 1'b0;
  logic       reset_n;
  logic       hold_req;
  logic [1:0] ratio_req;
  logic       power_mgmt_control_wr;
  logic [6:0] wr_pll_multiplier;
  logic [1:0] wr_post_div_sel;
  logic       wr_input_divide_enable;
  logic [2:0] wr_sdram_clock_ratio;
  logic       reference_clock_in;
  logic       board_reset_n;
  logic [1:0] ratio_select_pins;
  logic [6:0] pll_multiplier;
  logic [4:0] pll_post_divider;
  logic       input_divide_enable;
  logic [2:0] sdram_clock_ratio;
  logic [7:0] osc_to_input_ratio;
  logic       pll_input_en;
  logic       core_clk_en;
  logic       periph_clk_en;
  logic       sdram_clock_en;
  logic       core_reset_n;
  int         err_count = 0;
  int         compares = 0;
  int         cyc = 0;
  int         n;

  always #10 clk_sys = ~clk_sys;

  pll_clock_and_reset_release #(.REF_CYCLES(REF), .CORE_CYCLES(2))
    pll_clock_and_reset_release_inst (
    .clk_sys(clk_sys), .reset_n(reset_n), .reference_clock_in(reference_clock_in),
    .board_reset_n(board_reset_n), .ratio_select_pins(ratio_select_pins),
    .power_mgmt_control_wr(power_mgmt_control_wr), .wr_pll_multiplier(wr_pll_multiplier),
    .wr_post_div_sel(wr_post_div_sel), .wr_input_divide_enable(wr_input_divide_enable),
    .wr_sdram_clock_ratio(wr_sdram_clock_ratio), .pll_multiplier(pll_multiplier),
    .pll_post_divider(pll_post_divider), .input_divide_enable(input_divide_enable),
    .sdram_clock_ratio(sdram_clock_ratio), .osc_to_input_ratio(osc_to_input_ratio),
    .pll_input_en(pll_input_en), .core_clk_en(core_clk_en), .periph_clk_en(periph_clk_en),
    .sdram_clock_en(sdram_clock_en), .core_reset_n(core_reset_n));

  ref_board_model ref_board_model_inst (
    .clk_sys(clk_sys), .hold_req(hold_req), .ratio_req(ratio_req),
    .reference_clock_in(reference_clock_in), .board_reset_n(board_reset_n),
    .ratio_select_pins(ratio_select_pins));

  // ------
  // tasks
  // ------
  task automatic test_done;
    if (err_count == 0 && compares > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask

  task automatic check(input string nm, input logic [7:0] exp, input logic [7:0] got);
    compares++;
    if (got !== exp) begin
      err_count++;
      $display("CHECK FAILED %s exp %h got %h", nm, exp, got);
    end
  endtask

  task automatic tick(input int c);
    repeat (c) @(negedge clk_sys);
  endtask

  // small multipliers keep the oscillator in range
  task automatic wr(input logic [6:0] m, input logic [1:0] s, input logic d,
                    input logic [2:0] r);
    @(negedge clk_sys);
    power_mgmt_control_wr <= 1'b1;
    wr_pll_multiplier <= m;
    wr_post_div_sel <= s;
    wr_input_divide_enable <= d;
    wr_sdram_clock_ratio <= r;
    @(negedge clk_sys);
    power_mgmt_control_wr <= 1'b0;
    @(negedge clk_sys);
  endtask

  // reference rises seen from board release until core reset lifts
  task automatic rel(output int k);
    int t;
    logic p;
    k = 0;
    p = reference_clock_in;
    hold_req <= 1'b0;
    for (t = 0; t < 3000 && core_reset_n !== 1'b1; t++) begin
      @(negedge clk_sys);
      if (board_reset_n === 1'b1 && reference_clock_in === 1'b1 && !p) k++;
      p = reference_clock_in;
    end
  endtask

  function automatic logic pick(input int s);
    case (s)
      0: return core_clk_en;
      1: return periph_clk_en;
      2: return sdram_clock_en;
      default: return pll_input_en;
    endcase
  endfunction

  // spacing of two pulses, in cycles or in core pulses
  task automatic gap(input int s, input bit cu, output int k);
    int t;
    k = 1;
    for (t = 0; t < 600 && pick(s) !== 1'b1; t++) @(negedge clk_sys);
    @(negedge clk_sys);
    for (t = 0; t < 600 && pick(s) !== 1'b1; t++) begin
      if (!cu || core_clk_en === 1'b1) k++;
      @(negedge clk_sys);
    end
  endtask

  // ------
  // sequence
  // ------
  always @(posedge clk_sys) begin
    cyc++;
    if (cyc == 20000) begin
      err_count++;
      test_done();
    end
  end

  initial begin
    reset_n = 1'b0;
    hold_req = 1'b1;
    ratio_req = 2'h0;
    power_mgmt_control_wr = 1'b0;
    wr_pll_multiplier = 7'h00;
    wr_post_div_sel = 2'h0;
    wr_input_divide_enable = 1'b0;
    wr_sdram_clock_ratio = 3'h0;
    tick(12);
    reset_n <= 1'b1;
    for (int i = 0; i < 4; i++) begin
      hold_req <= 1'b1;
      ratio_req <= 2'(i);
      tick(30);
      check("mult", MT[i], pll_multiplier);
      check("div", 8'h02, pll_post_divider);
      rel(n);
      check("release", 8'h01, 8'(n >= REF && n <= REF + 3));
    end
    for (int i = 0; i < 4; i++) begin
      wr(7'h10 + 7'(i), 2'(i), i[0], 3'(2 * i + 1));
      tick(260);
      check("osc", 8'h20 + 8'(2 * i), osc_to_input_ratio);
      check("mult_wr", 8'h10 + 8'(i), pll_multiplier);
      check("divider", 8'h02 << i, pll_post_divider);
      check("input_divide_enable", 8'(i[0]), input_divide_enable);
      check("ratio", 8'(2 * i + 1), sdram_clock_ratio);
      gap(0, 1'b0, n);
      check("core", 8'h02 << i, 8'(n));
      gap(1, 1'b1, n);
      check("periph", 8'h02, 8'(n));
      gap(2, 1'b1, n);
      check("sdram", 8'(2 * i + 1), 8'(n));
      gap(3, 1'b0, n);
      check("input", 8'h04 << i[0], 8'(n));
    end
    hold_req <= 1'b1;
    ratio_req <= 2'h2;
    tick(6);
    wr(7'h55, 2'h1, 1'b1, 3'h4);
    tick(30);
    check("mult_hold", MT[2], pll_multiplier);
    check("div_hold", 8'h02, pll_post_divider);
    check("input_divide_enable_hold", 8'h00, input_divide_enable);
    hold_req <= 1'b0;
    tick(12);
    hold_req <= 1'b1;
    tick(30);
    check("core_rst", 8'h00, core_reset_n);
    rel(n);
    check("restart", 8'h01, 8'(n >= REF && n <= REF + 3));
    test_done();
  end
endmodule

`default_nettype wire
